// File: verilog/dmac_regs.svh
`ifndef DMAC_REGS_SVH
`define DMAC_REGS_SVH
// register indices on the plain register port
`define DMAC_OFS_CTRL 4'h0
`define DMAC_OFS_A_LO 4'h1
`define DMAC_OFS_A_HI 4'h2
`define DMAC_OFS_B_LO 4'h3
`define DMAC_OFS_B_HI 4'h4
`define DMAC_OFS_LEN 4'h5
`define DMAC_OFS_INTCNT 4'h6
`define DMAC_OFS_IDX 4'h7
`define DMAC_OFS_STAT 4'h8
`define DMAC_OFS_MASK 4'h9
// control field positions
`define DMAC_CTRL_RUN 0
`define DMAC_CTRL_IRQ_ALLOW 3
`define DMAC_CTRL_TRIG 4
`define DMAC_CTRL_B_STEP 5
`define DMAC_CTRL_A_STEP 6
`define DMAC_CTRL_CIRC 7
`define DMAC_CTRL_PACE 11
// writable control bits, 15:12 read as zero
`define DMAC_CTRL_WMASK 16'h0fff
`define DMAC_CTRL_RST 16'h0000
// status bits
`define DMAC_ST_MATCH 0
`define DMAC_ST_DONE 1
`define DMAC_ST_RST 2'h0
// channel count and wait cycles after a store
`define DMAC_NCH 4
`define DMAC_PACE_CYC 1
`endif

// File: verilog/dmac_pkg.sv
package dmac_pkg;
  // control register layout
  typedef struct packed {
    logic [3:0] rsvd;
    logic pace;
    logic [2:0] prio;
    logic circ;
    logic a_step;
    logic b_step;
    logic trig;
    logic irq_allow;
    logic [1:0] width;
    logic run;
  } dmac_ctrl_t;
  // one bus access issued by the channel
  typedef struct packed {
    logic [31:0] addr;
    logic we;
    logic [1:0] size;
    logic [31:0] wdata;
  } dmac_bus_cmd_t;
  // channel sequencing states
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_REQ, ST_ARB, ST_READ, ST_WRITE, ST_PACE
  } dmac_state_t;
endpackage

// File: verilog/dmac_channel.sv
`timescale 1ns/1ps
`include "dmac_regs.svh"
// How it works
// - pacing bit adds wait after each store but the last
// - trigger mode makes pacing bit irrelevant
// - bits 10:8 priority, larger value wins
// - equal priority: lower channel number wins
// - non-circular: stop after length, clear run
// - circular with trigger mode: reset index, restart, keep run
// - A step by 1/2/4 per width
// - B step by width bytes, else fixed
// - immediate start, or wait peripheral request
// - interrupt only with allow bit set
// - width field picks 1, 2, 4 bytes
// - run bit zero: channel idle, clocks off
// - hardware clears run unless circular with trigger mode
// - no pacing: hold bus against lower masters
// - interrupt when count equals index, pre-increment
// - length N moves N plus one items
module dmac_channel import dmac_pkg::*; #(
  parameter int CH_ID = 0
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // peripheral request from the request multiplexer
  input wire logic periph_req,
  // channel arbitration among all channels
  input wire logic [`DMAC_NCH-1:0] all_req,
  input wire logic [3*`DMAC_NCH-1:0] all_prio,
  output logic chan_req,
  output logic [2:0] chan_prio,
  // system bus master
  output logic bus_req,
  output logic bus_lock,
  input wire logic bus_gnt,
  output logic bus_valid,
  output dmac_bus_cmd_t bus_cmd,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  // clock gate enable and interrupt
  output logic clk_en,
  output logic irq
);

  // byte count per item, reserved code acts as one byte
  function automatic logic [2:0] item_bytes(input logic [1:0] w);
    case (w)
      2'h1: item_bytes = 3'h2;
      2'h2: item_bytes = 3'h4;
      default: item_bytes = 3'h1;
    endcase
  endfunction

  // address of item idx from a start address
  function automatic logic [31:0] item_addr(input logic [31:0] base, input logic step,
                                            input logic [15:0] idx, input logic [1:0] w);
    logic [31:0] ofs;
    // offset is the index times the item size in bytes
    ofs = 32'(idx) * 32'(item_bytes(w));
    // a cleared step bit keeps the address on the start
    item_addr = step ? base + ofs : base;
  endfunction

  // programmed registers
  dmac_ctrl_t ctrl_ff; // control word
  logic [31:0] a_start_ff; // source start
  logic [31:0] b_start_ff; // destination start
  logic [15:0] len_ff; // length minus one
  logic [15:0] intcnt_ff; // interrupt match count
  logic [15:0] idx_ff; // item index
  logic [1:0] stat_ff; // sticky events
  logic [1:0] mask_ff; // event mask
  logic [15:0] rdata_ff; // read return
  // sequencing
  dmac_state_t state_ff; // channel state
  logic [1:0] pace_cnt_ff; // wait cycles left
  dmac_bus_cmd_t cmd_ff; // registered bus command

  // decoded strobes and events
  logic wr_ctrl;
  logic item_done;
  logic last_item;
  logic wrap;
  logic [1:0] ev_set;
  logic pace_eff;
  logic win;

  // software write to the control word
  assign wr_ctrl = reg_wr && reg_addr == `DMAC_OFS_CTRL;
  // a store finishes one item
  assign item_done = state_ff == ST_WRITE && bus_ack;
  // last item when the index reaches the programmed length
  assign last_item = idx_ff == len_ff;
  // circular repeat only counts with request trigger
  assign wrap = ctrl_ff.circ && ctrl_ff.trig;
  // pacing only counts in immediate-start mode
  assign pace_eff = ctrl_ff.pace && !ctrl_ff.trig;

  // win when no other requester outranks this channel
  always_comb begin
    win = 1'b1;
    for (int i = 0; i < `DMAC_NCH; i++) begin
      // own request line is skipped
      if (i != CH_ID && all_req[i]) begin
        if (all_prio[3*i +: 3] > ctrl_ff.prio) begin
          win = 1'b0;
        end else if (all_prio[3*i +: 3] == ctrl_ff.prio && i < CH_ID) begin
          win = 1'b0;
        end
      end
    end
  end

  // event sources, match gated by the allow bit
  always_comb begin
    ev_set = 2'h0;
    ev_set[`DMAC_ST_MATCH] = item_done && ctrl_ff.irq_allow
                             && intcnt_ff == idx_ff;
    ev_set[`DMAC_ST_DONE] = item_done && last_item && ctrl_ff.irq_allow;
  end

  // control register, software write beats hardware clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff <= dmac_ctrl_t'(`DMAC_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_ff <= dmac_ctrl_t'(reg_wdata & `DMAC_CTRL_WMASK);
    end else if (item_done && last_item && !wrap) begin
      ctrl_ff.run <= 1'b0;
    end
  end

  // address, length and count registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_start_ff <= 32'h0;
      b_start_ff <= 32'h0;
      len_ff <= 16'h0;
      intcnt_ff <= 16'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `DMAC_OFS_A_LO: a_start_ff[15:0] <= reg_wdata;
        `DMAC_OFS_A_HI: a_start_ff[31:16] <= reg_wdata;
        `DMAC_OFS_B_LO: b_start_ff[15:0] <= reg_wdata;
        `DMAC_OFS_B_HI: b_start_ff[31:16] <= reg_wdata;
        `DMAC_OFS_LEN: len_ff <= reg_wdata;
        `DMAC_OFS_INTCNT: intcnt_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // sticky status with write-one-to-clear, set wins; mask
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_ff <= `DMAC_ST_RST;
      mask_ff <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == `DMAC_OFS_STAT) begin
        stat_ff <= (stat_ff & ~reg_wdata[1:0]) | ev_set;
      end else begin
        stat_ff <= stat_ff | ev_set;
      end
      if (reg_wr && reg_addr == `DMAC_OFS_MASK) begin
        mask_ff <= reg_wdata[1:0];
      end
    end
  end

  // read data, valid the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= 16'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `DMAC_OFS_CTRL: rdata_ff <= ctrl_ff;
        `DMAC_OFS_A_LO: rdata_ff <= a_start_ff[15:0];
        `DMAC_OFS_A_HI: rdata_ff <= a_start_ff[31:16];
        `DMAC_OFS_B_LO: rdata_ff <= b_start_ff[15:0];
        `DMAC_OFS_B_HI: rdata_ff <= b_start_ff[31:16];
        `DMAC_OFS_LEN: rdata_ff <= len_ff;
        `DMAC_OFS_INTCNT: rdata_ff <= intcnt_ff;
        `DMAC_OFS_IDX: rdata_ff <= idx_ff;
        `DMAC_OFS_STAT: rdata_ff <= {14'h0, stat_ff};
        `DMAC_OFS_MASK: rdata_ff <= {14'h0, mask_ff};
        default: rdata_ff <= 16'h0; // unmapped reads zero
      endcase
    end else begin
      rdata_ff <= 16'h0;
    end
  end

  // item index: advance per item, back to zero at the end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idx_ff <= 16'h0;
    end else if (!ctrl_ff.run) begin
      idx_ff <= 16'h0;
    end else if (item_done) begin
      idx_ff <= last_item ? 16'h0 : idx_ff + 16'h1;
    end
  end

  // channel sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      pace_cnt_ff <= 2'h0;
    end else if (!ctrl_ff.run) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        // start at once or wait for a request
        ST_IDLE: begin
          state_ff <= ctrl_ff.trig ? ST_WAIT_REQ : ST_ARB;
        end
        ST_WAIT_REQ: begin
          if (periph_req) begin
            state_ff <= ST_ARB;
          end
        end
        // contend for the bus before every item
        ST_ARB: begin
          if (win && bus_gnt) begin
            state_ff <= ST_READ;
          end
        end
        // fetch from the A side, then store
        ST_READ: begin
          if (bus_ack) begin
            state_ff <= ST_WRITE;
          end
        end
        // store done: pace, next item, wrap or stop
        ST_WRITE: begin
          if (bus_ack) begin
            if (last_item && !wrap) begin
              state_ff <= ST_IDLE;
            end else if (pace_eff) begin
              pace_cnt_ff <= 2'(`DMAC_PACE_CYC);
              state_ff <= ST_PACE;
            end else begin
              state_ff <= ctrl_ff.trig ? ST_WAIT_REQ : ST_ARB;
            end
          end
        end
        // idle cycle lets other masters take the bus
        ST_PACE: begin
          pace_cnt_ff <= pace_cnt_ff - 2'h1;
          if (pace_cnt_ff == 2'h1) begin
            state_ff <= ST_ARB;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // registered bus command for the next access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_ff <= '0;
    end else begin
      // item size follows the width field
      cmd_ff.size <= ctrl_ff.width;
      if (state_ff == ST_READ && bus_ack) begin
        cmd_ff.we <= 1'b1;
        cmd_ff.wdata <= bus_rdata;
        cmd_ff.addr <= item_addr(b_start_ff, ctrl_ff.b_step, idx_ff,
                                 ctrl_ff.width);
      end else if (state_ff != ST_READ && state_ff != ST_WRITE) begin
        cmd_ff.we <= 1'b0;
        cmd_ff.wdata <= 32'h0;
        cmd_ff.addr <= item_addr(a_start_ff, ctrl_ff.a_step, idx_ff,
                                 ctrl_ff.width);
      end
    end
  end

  // bus side outputs
  assign chan_req = state_ff == ST_ARB;
  assign chan_prio = ctrl_ff.prio;
  assign bus_req = state_ff == ST_ARB && win;
  // an access stands until its acknowledge
  assign bus_valid = state_ff == ST_READ || state_ff == ST_WRITE;
  assign bus_cmd = cmd_ff;
  // back-to-back mode keeps lower masters off between items
  assign bus_lock = ctrl_ff.run && !pace_eff && state_ff != ST_IDLE
                    && state_ff != ST_WAIT_REQ;
  // clocks of the channel run only while enabled
  assign clk_en = ctrl_ff.run;
  assign reg_rdata = rdata_ff;
  assign irq = |(stat_ff & mask_ff);

endmodule

// File: verification/dmac_channel_props.sv
`timescale 1ns/1ps
`include "dmac_regs.svh"
module dmac_channel_props import dmac_pkg::*; #(
  parameter int CH_ID = 0
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // arbitration
  input wire logic [`DMAC_NCH-1:0] all_req,
  input wire logic [3*`DMAC_NCH-1:0] all_prio,
  input wire logic chan_req,
  input wire logic [2:0] chan_prio,
  // system bus
  input wire logic bus_req,
  input wire logic bus_lock,
  input wire logic bus_gnt,
  input wire logic bus_valid,
  input wire dmac_bus_cmd_t bus_cmd,
  input wire logic bus_ack,
  input wire logic clk_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // true when another requesting channel outranks this one
  function automatic logic beaten(input logic [`DMAC_NCH-1:0] rq,
                                  input logic [3*`DMAC_NCH-1:0] pr, input logic [2:0] own);
    logic b;
    b = 1'b0;
    for (int j = 0; j < `DMAC_NCH; j++) begin
      if (j != CH_ID && rq[j] && (pr[3*j+:3] > own ||
          (pr[3*j+:3] == own && j < CH_ID))) begin
        b = 1'b1;
      end
    end
    return b;
  endfunction
  a_off_quiet: assert property (!clk_en |-> !chan_req && !bus_valid)
    else $error("channel active while off");
  a_prio_lose: assert property (beaten(all_req, all_prio, chan_prio) |-> !bus_req)
    else $error("bus taken from a stronger channel");
  a_prio_win: assert property (chan_req && !beaten(all_req, all_prio, chan_prio) |-> bus_req)
    else $error("winning channel did not request");
  a_grant_read: assert property (bus_req && bus_gnt |=> bus_valid && !bus_cmd.we)
    else $error("no read after grant");
  a_write_next: assert property (bus_valid && !bus_cmd.we && bus_ack |=>
    bus_valid && bus_cmd.we)
    else $error("no store after fetch");
  a_cmd_hold: assert property (bus_valid && !bus_ack |=> bus_valid && $stable(bus_cmd))
    else $error("access changed before ack");
  a_pace_gap: assert property (bus_valid && bus_cmd.we && bus_ack && !bus_lock |=>
    !chan_req)
    else $error("no wait cycle after store");
  a_lock_run: assert property (bus_lock |-> clk_en)
    else $error("bus held while off");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data outside its cycle");
  // main scenarios
  c_pace: cover property (bus_valid && bus_cmd.we && bus_ack && !bus_lock);
  c_lose: cover property (chan_req && beaten(all_req, all_prio, chan_prio));
  c_done: cover property ($fell(clk_en));
endmodule
bind dmac_channel dmac_channel_props #(.CH_ID(CH_ID)) u_dmac_channel_props (.clk, .sys_rst,
  .reg_rd, .reg_rdata, .all_req, .all_prio, .chan_req, .chan_prio, .bus_req, .bus_lock,
  .bus_gnt, .bus_valid, .bus_cmd, .bus_ack, .clk_en);

// File: verification/dmac_bus_model.sv
`timescale 1ns/1ps
// bus arbiter and memory seen by the channel
module dmac_bus_model import dmac_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // channel master side
  input wire logic bus_req,
  input wire logic bus_valid,
  input wire dmac_bus_cmd_t bus_cmd,
  output logic bus_gnt,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  // stalls chosen by the bench
  input wire logic gnt_hold,
  input wire logic [3:0] ack_dly
);
  logic [3:0] wait_ff; // cycles the current access has waited
  logic [31:0] ra_q[$], wa_q[$], wd_q[$]; // logged accesses
  // grant unless the processor side holds the bus
  assign bus_gnt = bus_req && !gnt_hold;
  // one-cycle ack after ack_dly cycles; read data do not linger
  always_ff @(posedge clk) begin
    if (sys_rst || !bus_valid || bus_ack) begin
      wait_ff <= 4'h0;
      bus_ack <= 1'b0;
      bus_rdata <= sys_rst ? 32'h0 : ~bus_rdata;
    end else if (wait_ff == ack_dly) begin
      bus_ack <= 1'b1;
      bus_rdata <= bus_cmd.addr ^ 32'h5a5a_0000;
      if (bus_cmd.we) begin
        wa_q.push_back(bus_cmd.addr);
        wd_q.push_back(bus_cmd.wdata);
      end else begin
        ra_q.push_back(bus_cmd.addr);
      end
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule

// File: verification/test_dmac_channel.sv
`timescale 1ns/1ps
`include "dmac_regs.svh"
module test_dmac_channel import dmac_pkg::*;;
  logic clk, sys_rst, reg_wr, reg_rd, periph_req, bus_req, bus_lock, bus_gnt;
  logic bus_valid, bus_ack, clk_en, irq, gnt_hold;
  logic [3:0] reg_addr, all_req, ack_dly;
  logic [15:0] reg_wdata, reg_rdata;
  logic [11:0] all_prio;
  logic [31:0] bus_rdata;
  dmac_bus_cmd_t bus_cmd;
  int fails, compares, cyc;
  localparam logic [31:0] A0 = 32'h0001_1000;
  localparam logic [31:0] B0 = 32'h0000_2000;
  dmac_channel #(.CH_ID(1)) u_dmac_channel (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .periph_req, .all_req, .all_prio, .chan_req(), .chan_prio(),
    .bus_req, .bus_lock, .bus_gnt, .bus_valid, .bus_cmd, .bus_ack, .bus_rdata, .clk_en, .irq);
  dmac_bus_model u_dmac_bus_model (.clk, .sys_rst, .bus_req, .bus_valid, .bus_cmd, .bus_gnt,
    .bus_ack, .bus_rdata, .gnt_hold, .ack_dly);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(32'(reg_rdata), 32'(e));
  endtask
  // clear the log, load length and control
  task automatic go(input logic [15:0] len, input logic [15:0] ctrl);
    u_dmac_bus_model.ra_q.delete();
    u_dmac_bus_model.wa_q.delete();
    u_dmac_bus_model.wd_q.delete();
    wr(`DMAC_OFS_LEN, len);
    wr(`DMAC_OFS_CTRL, ctrl);
  endtask
  // bounded wait for the run bit to drop
  task automatic fin();
    #1;
    for (int i = 0; i < 500 && clk_en !== 1'b0; i++) @(posedge clk);
    #1;
    chk(clk_en, 1'b0);
  endtask
  task automatic t_regs();
    rd(`DMAC_OFS_CTRL, 16'h0000);
    wr(`DMAC_OFS_CTRL, 16'hfffe);
    rd(`DMAC_OFS_CTRL, 16'h0ffe);
    wr(`DMAC_OFS_CTRL, 16'h0000);
    wr(`DMAC_OFS_A_HI, 16'h0001);
    wr(`DMAC_OFS_A_LO, 16'h1000);
    wr(`DMAC_OFS_B_LO, 16'h2000);
    rd(`DMAC_OFS_A_HI, 16'h0001);
    rd(4'hf, 16'h0000);
  endtask
  task automatic t_copy(input logic [1:0] w, input logic a, input logic b, input logic p);
    int n;
    n = 1 << w;
    go(16'h0003, {4'h0, p, 3'h2, 1'b0, a, b, 2'b00, w, 1'b1});
    fin();
    chk(clk_en, 1'b0);
    chk(u_dmac_bus_model.wa_q.size(), 4);
    for (int i = 0; i < 4; i++) begin
      chk(u_dmac_bus_model.ra_q[i], A0 + i * a * n);
      chk(u_dmac_bus_model.wa_q[i], B0 + i * b * n);
      if (w == 2'h2) chk(u_dmac_bus_model.wd_q[i], u_dmac_bus_model.ra_q[i] ^ 32'h5a5a_0000);
    end
  endtask
  task automatic t_circ();
    go(16'h0001, 16'h08d1);
    repeat (15) @(posedge clk);
    chk(u_dmac_bus_model.wa_q.size(), 0);
    periph_req <= 1'b1;
    for (int i = 0; i < 300 && u_dmac_bus_model.wa_q.size() < 3; i++) @(posedge clk);
    chk(clk_en, 1'b1);
    chk(u_dmac_bus_model.ra_q[2], A0);
    periph_req <= 1'b0;
    repeat (20) @(posedge clk);
    wr(`DMAC_OFS_CTRL, 16'h0000);
    #1 chk(clk_en, 1'b0);
  endtask
  task automatic t_irq();
    wr(`DMAC_OFS_MASK, 16'h0003);
    wr(`DMAC_OFS_INTCNT, 16'h0001);
    go(16'h0002, 16'h0069);
    fin();
    chk(irq, 1'b1);
    rd(`DMAC_OFS_STAT, 16'h0003);
    rd(`DMAC_OFS_IDX, 16'h0000);
    wr(`DMAC_OFS_STAT, 16'h0001);
    rd(`DMAC_OFS_STAT, 16'h0002);
    wr(`DMAC_OFS_MASK, 16'h0000);
    #1 chk(irq, 1'b0);
    wr(`DMAC_OFS_STAT, 16'h0002);
    go(16'h0002, 16'h0061);
    fin();
    rd(`DMAC_OFS_STAT, 16'h0000);
    wr(`DMAC_OFS_INTCNT, 16'h0003);
    go(16'h0002, 16'h0069);
    fin();
    rd(`DMAC_OFS_STAT, 16'h0002);
  endtask
  task automatic t_prio();
    @(posedge clk);
    all_prio <= 12'h0c3;
    all_req <= 4'h5;
    ack_dly <= 4'h3;
    go(16'h0001, 16'h0361);
    repeat (20) @(posedge clk);
    chk(u_dmac_bus_model.wa_q.size(), 0);
    all_prio <= 12'h102;
    repeat (20) @(posedge clk);
    chk(u_dmac_bus_model.wa_q.size(), 0);
    gnt_hold <= 1'b1;
    all_prio <= 12'h0c2;
    repeat (10) @(posedge clk);
    chk(u_dmac_bus_model.ra_q.size(), 0);
    gnt_hold <= 1'b0;
    fin();
    chk(u_dmac_bus_model.wa_q.size(), 2);
    all_req <= 4'h0;
    ack_dly <= 4'h0;
  endtask
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, periph_req, gnt_hold} = 5'h10;
    {reg_addr, all_req, ack_dly, reg_wdata, all_prio} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_copy(2'h0, 1'b1, 1'b0, 1'b0);
    t_copy(2'h1, 1'b0, 1'b1, 1'b1);
    t_copy(2'h2, 1'b1, 1'b1, 1'b0);
    t_circ();
    t_irq();
    t_prio();
    finish_test();
  end
endmodule
